// ===== rtl/analog_frontend_config_regs.sv
// Front-end buffer and chop / common-mode configuration registers
// Operation
// R1: Front-end bits 7:6 pick positive reference buffering: precharge, unbuffered, full.
// R2: Front-end bits 5:4 pick negative reference buffering, same encoding.
// R3: Front-end bit 1 set disables positive input precharge buffer.
// R4: Front-end bit 0 set disables negative input precharge buffer.
// R5: Chop bit 7 clear gives chop at modulator clock over 32, default.
// R6: Chop bit 7 set gives chop at modulator clock over 8.
// R7: Chop bits 2:0 pick common-mode level; 111 switches output off.
// R8: Reset clears front-end buffer register at 0x16.
// R9: Reset clears chop and common-mode register at 0x17.
// R10: Reserved bits read zero and ignore writes.
`include "afe_cfg_map.svh"

module analog_frontend_config_regs
    import afe_cfg_pkg::*;
(
    input  wire logic           mclk,
    input  wire logic           rst,
    input  wire logic           reg_wr_en,
    input  wire logic           reg_rd_en,
    input  wire logic [6:0]     reg_addr,
    input  wire logic [7:0]     reg_wdata,
    output logic      [7:0]     reg_rdata,
    output logic                reg_rd_hit,
    output front_end_cfg_t      front_end_cfg,
    output chop_vcm_cfg_t       chop_vcm_cfg
);

    // Stored register images and their masked next values
    logic [7:0]     front_end_buffer_ctrl_q;
    logic [7:0]     chop_and_common_mode_ctrl_q;
    logic [7:0]     front_end_buffer_ctrl_d;
    logic [7:0]     chop_and_common_mode_ctrl_d;

    // Qualified strobes and read-back value
    logic           front_end_wr;
    logic           chop_wr;
    logic           front_end_rd;
    logic           chop_rd;
    logic           mapped_rd;
    logic [7:0]     rd_value;

    // Decoded controls ahead of the output flops
    front_end_cfg_t front_end_cfg_d;
    chop_vcm_cfg_t  chop_vcm_cfg_d;

    // Address match shared by the write and read paths
    function automatic logic hits_front_end(
        input logic [6:0] addr
    );
        return addr == `FEB_ADDR;
    endfunction : hits_front_end

    function automatic logic hits_chop(
        input logic [6:0] addr
    );
        return addr == `CCM_ADDR;
    endfunction : hits_chop

    // Reserved fields dropped on write so they can never hold a one
    function automatic logic [7:0] mask_write(
        input logic [7:0] value,
        input logic [7:0] mask
    );
        return value & mask;
    endfunction : mask_write

    // Both reference inputs share one encoding; code 11 passes on as ref_invalid
    function automatic ref_buf_mode_t ref_mode(
        input logic [1:0] code
    );
        return ref_buf_mode_t'(code);
    endfunction : ref_mode

    function automatic logic precharge_on(
        input logic off
    );
        return !off;
    endfunction : precharge_on

    // Ratio handed on as a number; the chop timing itself lives downstream
    function automatic logic [5:0] chop_divisor(
        input logic fast
    );
        logic [5:0] ratio;
        if (fast) begin
            ratio = `CHOP_DIV_FAST; // R6
        end else begin
            ratio = `CHOP_DIV_SLOW; // R5
        end
        return ratio;
    endfunction : chop_divisor

    // Reset value goes through here too, so reset and run share one mapping
    function automatic front_end_cfg_t decode_front_end(
        input logic [7:0] value
    );
        front_end_cfg_t cfg;
        cfg.positive_reference_buffer_select =
            ref_mode(value[`FEB_POS_REF_HI:`FEB_POS_REF_LO]); // R1
        cfg.negative_reference_buffer_select =
            ref_mode(value[`FEB_NEG_REF_HI:`FEB_NEG_REF_LO]); // R2
        cfg.positive_input_precharge_disable = value[`FEB_POS_AIN_BIT];               // R3
        cfg.positive_input_precharge_enable  = precharge_on(value[`FEB_POS_AIN_BIT]); // R3
        cfg.negative_input_precharge_disable = value[`FEB_NEG_AIN_BIT];               // R4
        cfg.negative_input_precharge_enable  = precharge_on(value[`FEB_NEG_AIN_BIT]); // R4
        return cfg;
    endfunction : decode_front_end

    function automatic chop_vcm_cfg_t decode_chop(
        input logic [7:0] value
    );
        chop_vcm_cfg_t cfg;
        cfg.chop_fast                 = value[`CCM_CHOP_BIT];               // R6
        cfg.chop_divide               = chop_divisor(value[`CCM_CHOP_BIT]); // R5
        cfg.common_mode_output_select =
            vcm_level_t'(value[`CCM_VCM_HI:`CCM_VCM_LO]); // R7
        // Code 111 switches the pin off rather than picking a level
        cfg.common_mode_output_enable =
            value[`CCM_VCM_HI:`CCM_VCM_LO] != 3'h7; // R7
        return cfg;
    endfunction : decode_chop

    // Write decode; unmapped addresses leave both registers alone
    always_comb begin
        front_end_wr = 1'b0;
        chop_wr      = 1'b0;
        if (reg_wr_en && hits_front_end(reg_addr)) begin
            front_end_wr = 1'b1;
        end else if (reg_wr_en && hits_chop(reg_addr)) begin
            chop_wr = 1'b1;
        end
    end

    // Read decode; anything else reads as zero with no hit
    always_comb begin
        front_end_rd = 1'b0;
        chop_rd      = 1'b0;
        if (reg_rd_en && hits_front_end(reg_addr)) begin
            front_end_rd = 1'b1;
        end else if (reg_rd_en && hits_chop(reg_addr)) begin
            chop_rd = 1'b1;
        end
    end

    always_comb begin
        mapped_rd = front_end_rd || chop_rd;
    end

    always_comb begin
        if (front_end_rd) begin
            rd_value = front_end_buffer_ctrl_q; // R10
        end else if (chop_rd) begin
            rd_value = chop_and_common_mode_ctrl_q; // R10
        end else begin
            rd_value = 8'h00;
        end
    end

    always_comb begin
        front_end_buffer_ctrl_d = mask_write(reg_wdata, `FEB_WMASK); // R10
    end

    always_comb begin
        chop_and_common_mode_ctrl_d = mask_write(reg_wdata, `CCM_WMASK); // R10
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            front_end_buffer_ctrl_q <= `FEB_RESET; // R8
        end else if (front_end_wr) begin
            front_end_buffer_ctrl_q <= front_end_buffer_ctrl_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            chop_and_common_mode_ctrl_q <= `CCM_RESET; // R9
        end else if (chop_wr) begin
            chop_and_common_mode_ctrl_q <= chop_and_common_mode_ctrl_d;
        end
    end

    // Read data registered so it stays stable through the serial shift-out
    always_ff @(posedge mclk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd_en) begin
            reg_rdata <= rd_value;
        end
    end

    // One-cycle pulse per mapped read
    always_ff @(posedge mclk) begin
        if (rst) begin
            reg_rd_hit <= 1'b0;
        end else begin
            reg_rd_hit <= mapped_rd;
        end
    end

    always_comb begin
        front_end_cfg_d = decode_front_end(front_end_buffer_ctrl_q);
    end

    always_comb begin
        chop_vcm_cfg_d = decode_chop(chop_and_common_mode_ctrl_q);
    end

    // Decoded controls follow the register one cycle later
    always_ff @(posedge mclk) begin
        if (rst) begin
            front_end_cfg <= decode_front_end(`FEB_RESET); // R8
        end else begin
            front_end_cfg <= front_end_cfg_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            chop_vcm_cfg <= decode_chop(`CCM_RESET); // R9
        end else begin
            chop_vcm_cfg <= chop_vcm_cfg_d;
        end
    end

endmodule : analog_frontend_config_regs

// ===== rtl/afe_cfg_map.svh
// Register offsets, field positions and reset values of the front-end config bank
`ifndef AFE_CFG_MAP_SVH
`define AFE_CFG_MAP_SVH
`define FEB_ADDR        7'h16
`define CCM_ADDR        7'h17
`define FEB_RESET       8'h00
`define CCM_RESET       8'h00
`define FEB_POS_REF_HI  7
`define FEB_POS_REF_LO  6
`define FEB_NEG_REF_HI  5
`define FEB_NEG_REF_LO  4
`define FEB_POS_AIN_BIT 1
`define FEB_NEG_AIN_BIT 0
`define FEB_WMASK       8'hf3
`define CCM_CHOP_BIT    7
`define CCM_VCM_HI      2
`define CCM_VCM_LO      0
`define CCM_WMASK       8'h87
`define CHOP_DIV_SLOW   6'h20
`define CHOP_DIV_FAST   6'h08
`endif

// ===== rtl/afe_cfg_pkg.sv
// Types for the front-end configuration register bank
package afe_cfg_pkg;
    typedef enum logic [1:0] {
        ref_precharge,
        ref_unbuffered,
        ref_full,
        ref_invalid
    } ref_buf_mode_t;

    typedef enum logic [2:0] {
        vcm_mid_supply,
        vcm_2v50,
        vcm_2v05,
        vcm_1v90,
        vcm_1v65,
        vcm_1v10,
        vcm_0v90,
        vcm_off
    } vcm_level_t;

    typedef struct packed {
        ref_buf_mode_t positive_reference_buffer_select;
        ref_buf_mode_t negative_reference_buffer_select;
        logic          positive_input_precharge_disable;
        logic          negative_input_precharge_disable;
        logic          positive_input_precharge_enable;
        logic          negative_input_precharge_enable;
    } front_end_cfg_t;

    typedef struct packed {
        logic       chop_fast;
        logic [5:0] chop_divide;
        vcm_level_t common_mode_output_select;
        logic       common_mode_output_enable;
    } chop_vcm_cfg_t;
endpackage : afe_cfg_pkg

// ===== test/afe_cfg_monitor.sv
// Assertions for the front-end config bank
module afe_cfg_monitor
    import afe_cfg_pkg::*;
(
    input logic           mclk,
    input logic           rst,
    input logic           reg_wr_en,
    input logic           reg_rd_en,
    input logic [6:0]     reg_addr,
    input logic [7:0]     reg_wdata,
    input logic [7:0]     reg_rdata,
    input logic           reg_rd_hit,
    input front_end_cfg_t front_end_cfg,
    input chop_vcm_cfg_t  chop_vcm_cfg
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    wire [7:0]  fe = front_end_cfg;
    wire [10:0] cv = chop_vcm_cfg;
    wire w16 = reg_wr_en && reg_addr==7'h16;
    wire w17 = reg_wr_en && reg_addr==7'h17;
    property p_ref; w16 |-> ##2 fe[7:4]==$past(reg_wdata[7:4], 2); endproperty
    a_ref: assert property (p_ref) else $error("ref mode");
    property p_ain; w16 |-> ##2 fe[3:0]=={$past(reg_wdata[1:0], 2), ~fe[3:2]}; endproperty
    a_ain: assert property (p_ain) else $error("precharge");
    property p_div; cv[9:4]==(cv[10] ? 6'h08 : 6'h20); endproperty
    a_div: assert property (p_div) else $error("chop divide");
    property p_chop;
        w17 |-> ##2 cv[10:1]=={$past(reg_wdata[7], 2), cv[9:4], $past(reg_wdata[2:0], 2)};
    endproperty
    a_chop: assert property (p_chop) else $error("chop write");
    property p_vcm; cv[0]==(cv[3:1]!=3'h7); endproperty
    a_vcm: assert property (p_vcm) else $error("vcm enable");
    property p_rst; $fell(rst) |-> fe==8'h03 && cv==11'h201 && reg_rdata==8'h00; endproperty
    a_rst: assert property (p_rst) else $error("reset");
    property p_rsvd;
        reg_rd_en && reg_addr==7'h17 |=> reg_rd_hit && reg_rdata[6:3]==4'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved");
    property p_miss; reg_rd_en && reg_addr>7'h17 |=> !reg_rd_hit && reg_rdata==8'h00; endproperty
    a_miss: assert property (p_miss) else $error("unmapped");
endmodule : afe_cfg_monitor
bind analog_frontend_config_regs afe_cfg_monitor u_mon (.*);

// ===== test/afe_cfg_host.sv
// Host model driving the register strobes
module afe_cfg_host (
    input  wire logic  mclk,
    output logic       reg_wr_en = 1'b0,
    output logic       reg_rd_en = 1'b0,
    output logic [6:0] reg_addr = 7'h00,
    output logic [7:0] reg_wdata = 8'h00
);
    timeunit 1ns;
    timeprecision 1ps;
    // Strobes dropped, address and data inverted so stale values never look valid
    task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d);
        @(negedge mclk);
        {reg_wr_en, reg_rd_en, reg_addr, reg_wdata} <= {w, !w, a, d};
        @(negedge mclk);
        {reg_wr_en, reg_rd_en, reg_addr, reg_wdata} <= {2'b00, ~a, ~d};
    endtask : acc
endmodule : afe_cfg_host

// ===== test/analog_frontend_config_regs_bench.sv
// Bench for the front-end config bank
module analog_frontend_config_regs_bench
    import afe_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    `define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
        $display("MISMATCH %0t value %h", $time, a); end end
    logic mclk = 1'b0, rst = 1'b1, reg_wr_en, reg_rd_en, reg_rd_hit;
    logic [6:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    front_end_cfg_t front_end_cfg;
    chop_vcm_cfg_t chop_vcm_cfg;
    int error_cnt = 0, checks_done = 0;
    logic [23:0] rows [7] = '{24'h16fff3, 24'h160000, 24'h17ff87, 24'h177800,
                              24'h165a52, 24'h16a2a2, 24'h18ff00};
    analog_frontend_config_regs u_dut (.*);
    afe_cfg_host u_host (.*);
    initial forever #5 mclk = ~mclk;
    task automatic test_done;
        if (error_cnt == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : test_done
    initial begin
        repeat (5) @(negedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            u_host.acc(1'b1, rows[i][22:16], rows[i][15:8]);
            u_host.acc(1'b0, rows[i][22:16], 8'h00);
            `CHK(reg_rdata, rows[i][7:0])
            `CHK(reg_rd_hit, rows[i][23:16] != 8'h18)
            if (rows[i][23:16] == 8'h16) begin
                `CHK(front_end_cfg, {rows[i][7:4], rows[i][1:0], ~rows[i][1:0]})
            end
            if (rows[i][23:16] == 8'h17) begin
                `CHK(chop_vcm_cfg[10:4], {rows[i][7], rows[i][7] ? 6'h08 : 6'h20})
            end
        end
        // Every vcm code, chop rate toggled alongside
        for (int i = 0; i < 8; i++) begin
            u_host.acc(1'b1, 7'h17, {i[0], 4'h0, i[2:0]});
            repeat (2) @(negedge mclk);
            `CHK(chop_vcm_cfg[3:0], {i[2:0], i[2:0] != 3'h7})
            `CHK(chop_vcm_cfg[9:4], i[0] ? 6'h08 : 6'h20)
            `CHK(chop_vcm_cfg[10], i[0])
        end
        @(negedge mclk) rst <= 1'b1;
        @(negedge mclk) rst <= 1'b0;
        u_host.acc(1'b0, 7'h17, 8'h00);
        `CHK(reg_rdata, 8'h00)
        `CHK(front_end_cfg, 8'h03)
        `CHK(chop_vcm_cfg, 11'h201)
        test_done;
    end
endmodule : analog_frontend_config_regs_bench
